// ==== src/icp_pkg.sv ====
package icp_pkg;

	// Line states of the snoop outcome
	localparam logic [1:0] ICP_LINE_INVALID  = 2'h0;
	localparam logic [1:0] ICP_LINE_SHARED   = 2'h1;
	localparam logic [1:0] ICP_LINE_EXCL     = 2'h2;
	localparam logic [1:0] ICP_LINE_MODIFIED = 2'h3;

	// Transfer counts per bus cycle
	localparam logic [1:0] ICP_LEN_SINGLE = 2'h0;
	localparam logic [1:0] ICP_LEN_BURST  = 2'h3;

	// Acknowledge cycles per accepted request
	localparam logic [1:0] ICP_ACK_COUNT = 2'h2;

	// Vector width
	localparam int ICP_VEC_W = 8;

	typedef enum logic [2:0] {
		ICP_IDLE,
		ICP_WAIT_INSN,
		ICP_ACK_REQ,
		ICP_ACK_WAIT,
		ICP_VECTOR
	} icp_state_t;

endpackage

// ==== src/icp_pin_route.sv ====
`timescale 1ns/1ns
module icp_pin_route (
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic local_ctrl_enable,
	input  wire logic pin_zero,
	input  wire logic pin_one,
	output logic      maskable_req,
	output logic      nonmaskable_req,
	output logic      local_irq_zero,
	output logic      local_irq_one
);
	import icp_pkg::*;

	// Registered so downstream sees one-cycle-aligned, glitch-free levels
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			maskable_req    <= 1'b0;
			nonmaskable_req <= 1'b0;
			local_irq_zero  <= 1'b0;
			local_irq_one   <= 1'b0;
		end else begin
			maskable_req    <= pin_zero & ~local_ctrl_enable;
			local_irq_zero  <= pin_zero & local_ctrl_enable;
			nonmaskable_req <= pin_one & ~local_ctrl_enable;
			local_irq_one   <= pin_one & local_ctrl_enable;
		end
	end
endmodule

// ==== src/icp_top.sv ====
`timescale 1ns/1ns
module icp_top (
	input  wire logic                         clock,
	input  wire logic                         reset_n,
	input  wire logic                         irq_pin_zero,
	input  wire logic                         irq_pin_one,
	input  wire logic                         local_ctrl_enable,
	input  wire logic                         irq_enable_flag,
	input  wire logic                         insn_boundary,
	input  wire logic                         ack_cycle_done,
	input  wire logic [icp_pkg::ICP_VEC_W-1:0] ack_vector,
	input  wire logic                         snoop_address_strobe_n,
	input  wire logic                         snoop_invalidate_qualifier,
	input  wire logic                         snoop_hit,
	input  wire logic [1:0]                   snoop_cur_state,
	input  wire logic                         cycle_start,
	input  wire logic                         cacheable_cycle,
	input  wire logic                         cache_allow_n,
	output logic                              ack_cycle_req,
	output logic                              bus_lock,
	output logic                              hold_execution,
	output logic                              vector_valid,
	output logic [icp_pkg::ICP_VEC_W-1:0]     vector_out,
	output logic                              nmi_request,
	output logic                              local_irq_zero,
	output logic                              local_irq_one,
	output logic                              snoop_update,
	output logic [1:0]                        snoop_new_state,
	output logic                              line_fill,
	output logic [1:0]                        cycle_length
);
	import icp_pkg::*;

	logic       maskable_req;
	icp_state_t state_reg;
	logic [1:0] ack_cnt_reg;
	logic       accept_now;
	logic       start_ack;
	logic       ack_done_now;
	logic       last_ack;

	// Request qualified by the enable flag, re-tested every clock
	assign accept_now   = maskable_req && irq_enable_flag;
	assign start_ack    = (state_reg == ICP_WAIT_INSN) && accept_now &&
		insn_boundary;
	assign ack_done_now = (state_reg == ICP_ACK_WAIT) && ack_cycle_done;
	assign last_ack     = (ack_cnt_reg + 2'h1) == ICP_ACK_COUNT;

	icp_pin_route u_route (
		.clock             (clock),
		.reset_n           (reset_n),
		.local_ctrl_enable (local_ctrl_enable),
		.pin_zero          (irq_pin_zero),
		.pin_one           (irq_pin_one),
		.maskable_req      (maskable_req),
		.nonmaskable_req   (nmi_request),
		.local_irq_zero    (local_irq_zero),
		.local_irq_one     (local_irq_one)
	);

	////////////////////////////////////////////////////////////////////////
	// Interrupt acceptance and acknowledge sequencing
	// Request is not latched: a request dropped before the instruction
	// boundary is simply lost, so the requester must hold it.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_reg <= ICP_IDLE;
		end else begin
			case (state_reg)
				ICP_IDLE: begin
					if (accept_now) begin
						state_reg <= ICP_WAIT_INSN;
					end
				end
				ICP_WAIT_INSN: begin
					if (!accept_now) begin
						state_reg <= ICP_IDLE;
					end else if (insn_boundary) begin
						state_reg <= ICP_ACK_REQ;
					end
				end
				ICP_ACK_REQ: begin
					state_reg <= ICP_ACK_WAIT;
				end
				ICP_ACK_WAIT: begin
					if (ack_cycle_done) begin
						state_reg <= last_ack ? ICP_VECTOR : ICP_ACK_REQ;
					end
				end
				ICP_VECTOR: begin
					state_reg <= ICP_IDLE;
				end
				default: begin
					state_reg <= ICP_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Acknowledge counter, cleared at every new acceptance
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ack_cnt_reg <= 2'h0;
		end else if (start_ack) begin
			ack_cnt_reg <= 2'h0;
		end else if (ack_done_now && !last_ack) begin
			ack_cnt_reg <= ack_cnt_reg + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Acknowledge request: one level per cycle, dropped on done
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ack_cycle_req <= 1'b0;
		end else if (state_reg == ICP_ACK_REQ) begin
			ack_cycle_req <= 1'b1;
		end else if (ack_done_now) begin
			ack_cycle_req <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Lock spans both acknowledges so no other master slips between
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			bus_lock <= 1'b0;
		end else if (start_ack) begin
			bus_lock <= 1'b1;
		end else if (ack_done_now && last_ack) begin
			bus_lock <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Execution held from the boundary until the vector is out
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			hold_execution <= 1'b0;
		end else if (start_ack) begin
			hold_execution <= 1'b1;
		end else if (state_reg == ICP_VECTOR) begin
			hold_execution <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Vector captured with the second done only
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			vector_out <= '0;
		end else if (ack_done_now && last_ack) begin
			vector_out <= ack_vector;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			vector_valid <= 1'b0;
		end else begin
			vector_valid <= (state_reg == ICP_VECTOR);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Snoop outcome, qualifier taken in the strobe clock only
	// Current line state is not needed: the outcome depends on the
	// qualifier alone
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			snoop_update <= 1'b0;
		end else begin
			snoop_update <= !snoop_address_strobe_n && snoop_hit;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			snoop_new_state <= ICP_LINE_INVALID;
		end else if (!snoop_address_strobe_n && snoop_hit) begin
			snoop_new_state <= snoop_invalidate_qualifier ?
				ICP_LINE_INVALID : ICP_LINE_SHARED;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cycle length decision
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			line_fill    <= 1'b0;
			cycle_length <= ICP_LEN_SINGLE;
		end else begin
			line_fill <= 1'b0;
			if (cycle_start) begin
				line_fill    <= cacheable_cycle & ~cache_allow_n;
				cycle_length <= (cacheable_cycle && !cache_allow_n) ?
					ICP_LEN_BURST : ICP_LEN_SINGLE;
			end
		end
	end
endmodule

// ==== testbench/icp_asserts.sv ====
`timescale 1ns/1ns
module icp_asserts import icp_pkg::*; (
	input wire logic clock, reset_n, irq_pin_zero, irq_pin_one,
	input wire logic local_ctrl_enable, irq_enable_flag, cycle_start,
	input wire logic snoop_address_strobe_n, snoop_invalidate_qualifier,
	input wire logic snoop_hit, cacheable_cycle, cache_allow_n, bus_lock,
	input wire logic vector_valid, nmi_request, local_irq_zero,
	input wire logic local_irq_one, snoop_update, line_fill,
	input wire logic [1:0] snoop_new_state, cycle_length
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	wire snp = !snoop_address_strobe_n && snoop_hit;
	wire fill = cycle_start && cacheable_cycle && !cache_allow_n;
	a_route_zero: assert property ($past(reset_n) |-> local_irq_zero ==
		$past(irq_pin_zero && local_ctrl_enable)) else $error("pin zero");
	a_route_one: assert property ($past(reset_n) |-> {nmi_request,
		local_irq_one} == {$past(irq_pin_one && !local_ctrl_enable),
		$past(irq_pin_one && local_ctrl_enable)}) else $error("pin one");
	a_snoop_state: assert property (snp |=> snoop_update &&
		snoop_new_state == ($past(snoop_invalidate_qualifier) ?
		ICP_LINE_INVALID : ICP_LINE_SHARED)) else $error("snoop state");
	a_snoop_idle: assert property (!snp |=> !snoop_update)
		else $error("snoop spurious");
	a_burst_fill: assert property (fill |=> line_fill &&
		cycle_length == ICP_LEN_BURST) else $error("no burst");
	a_single_len: assert property (cycle_start && !fill |=> !line_fill &&
		cycle_length == ICP_LEN_SINGLE) else $error("bad single");
	a_flag_clear: assert property ((!bus_lock && !irq_enable_flag)[*4]
		|=> !bus_lock) else $error("masked ack");
	a_vector_end: assert property ($fell(bus_lock) |=> vector_valid)
		else $error("no vector");
	c_vector: cover property ($rose(vector_valid));
	c_inval: cover property (snp && snoop_invalidate_qualifier);
	c_fill: cover property (fill);
endmodule
bind icp_top icp_asserts u_chk (.*);

// ==== testbench/icp_sys_model.sv ====
`timescale 1ns/1ns
module icp_sys_model #(parameter logic [7:0] VEC = 8'hA5) (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       slow,
	input  wire logic       ack_cycle_req,
	output logic            ack_cycle_done,
	output logic [7:0]      ack_vector
);
	logic [1:0] n_reg;
	// Inverted outside done so a stale sample shows
	assign ack_vector = ack_cycle_done ? VEC : ~VEC;
	always_ff @(posedge clock) begin
		ack_cycle_done <= 1'b0;
		if (!reset_n || !ack_cycle_req || ack_cycle_done) n_reg <= 2'h0;
		else if (n_reg == (slow ? 2'h3 : 2'h0)) ack_cycle_done <= 1'b1;
		else n_reg <= n_reg + 2'h1;
	end
endmodule

// ==== testbench/test_icp_top.sv ====
`timescale 1ns/1ns
module test_icp_top;
	import icp_pkg::*;
	logic clock = 0, reset_n = 0, slow = 0, irq_pin_zero = 0, irq_pin_one = 0;
	logic local_ctrl_enable = 0, irq_enable_flag = 0, insn_boundary = 0;
	logic snoop_address_strobe_n = 1, snoop_invalidate_qualifier = 0;
	logic snoop_hit = 0, cycle_start = 0, cacheable_cycle = 0;
	logic cache_allow_n = 1, ack_cycle_done, ack_cycle_req, bus_lock;
	logic hold_execution, vector_valid, nmi_request, local_irq_zero;
	logic local_irq_one, snoop_update, line_fill;
	logic [1:0] snoop_new_state, cycle_length, snoop_cur_state = 2'h0;
	logic [7:0] ack_vector, vector_out;
	logic [31:0] r, rs = 32'h36;
	int errors = 0, checks_done = 0, k, acks, vvs;
	always #4 clock = ~clock;
	icp_sys_model #(.VEC(8'hA5)) sys (.*);
	icp_top DUT (.*);
	function logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task chk(input logic [7:0] g, e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task report_and_stop();
		$display("checks=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge clock);
		reset_n = 1;
		for (k = 0; k < 40; k++) begin
			// First two: snoop hit both ways plus a burst fill
			r = (k < 2) ? (32'hD0 | (k << 5)) : rnd();
			{cache_allow_n, cacheable_cycle, cycle_start} = r[8:6];
			{snoop_invalidate_qualifier, snoop_hit} = r[5:4];
			{snoop_address_strobe_n, local_ctrl_enable} = r[3:2];
			{irq_pin_one, irq_pin_zero} = r[1:0];
			@(negedge clock);
			chk(local_irq_zero, r[0] & r[2]);
			chk({nmi_request, local_irq_one}, {r[1] & !r[2], r[1] & r[2]});
			chk(snoop_update, !r[3] & r[4]);
			if (!r[3] & r[4]) chk(snoop_new_state,
				r[5] ? ICP_LINE_INVALID : ICP_LINE_SHARED);
			if (r[6]) chk({line_fill, cycle_length},
				(r[7] & !r[8]) ? {1'b1, ICP_LEN_BURST} : {1'b0, ICP_LEN_SINGLE});
		end
		{snoop_address_strobe_n, cycle_start} = 2'h2;
		$display("pin route, snoop and cycle test done");
		for (k = 0; k < 3; k++) begin
			{slow, irq_enable_flag} = {k[0], k < 2};
			{irq_pin_zero, local_ctrl_enable, acks, vvs} = 0;
			irq_pin_zero = 1;
			repeat (3) @(negedge clock);
			insn_boundary = 1;
			@(negedge clock);
			insn_boundary = 0;
			repeat (40) begin
				@(negedge clock);
				if (ack_cycle_req) irq_pin_zero = 0;
				acks += ack_cycle_done;
				vvs += vector_valid;
				if (vector_valid) chk(vector_out, 8'hA5);
				if (vector_valid) chk({bus_lock, hold_execution}, 2'h0);
				if (ack_cycle_req) chk({bus_lock, hold_execution}, 2'h3);
			end
			irq_pin_zero = 0;
			chk(acks, (k < 2) ? 2 : 0);
			chk(vvs, k < 2);
			$display("interrupt test %0d done", k);
		end
		report_and_stop();
	end
endmodule
